//--- snfe_top.sv
// Serial command front end of a NAND flash: link decode plus core control.
// Assumes a host driving sclk and cs_n; array engine answers op_done.
`default_nettype none

module snfe_top
	import snfe_pkg::*;
#(
	parameter logic [7:0] MFR_CODE   = 8'h5A, // arbitrary value
	parameter logic [7:0] PART_CODE  = 8'hA5, // arbitrary value
	parameter bit         DENSITY_2G = 1'b0
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        io_lane0_in,
	output logic             io_lane0_out,
	output logic             io_lane0_oe,
	input  wire logic        io_lane1_in,
	output logic             io_lane1_out,
	output logic             io_lane1_oe,
	input  wire logic        io_lane2_in,
	output logic             io_lane2_out,
	output logic             io_lane2_oe,
	input  wire logic        io_lane3_in,
	output logic             io_lane3_out,
	output logic             io_lane3_oe,
	input  wire logic        op_done,
	input  wire logic        op_fail,
	input  wire logic [1:0]  op_ecc,
	output logic             op_start,
	output snfe_op_t         op_kind,
	output logic             op_abort,
	output logic [23:0]      row_addr,
	output logic [5:0]       page_addr,
	output logic [10:0]      block_addr,
	output logic             busy,
	output logic             write_latch,
	output logic             program_fail,
	output logic             erase_fail,
	output logic [1:0]       ecc_status,
	output logic             protect_lock_enable,
	output logic             prot_level_bit0,
	output logic             prot_level_bit1,
	output logic             prot_level_bit2,
	output logic             prot_invert,
	output logic             prot_complement,
	output logic             quad_lane_enable
);

	typedef enum {L_OPC, L_ADDR, L_DUMMY, L_DATA, L_SKIP} snfe_lstate_t;

	// Link domain state
	snfe_lstate_t state;
	snfe_cmd_t    cmd;
	snfe_cmd_t    dec;
	logic [4:0]   cnt;
	logic [23:0]  sh_in;
	logic [23:0]  addr;
	logic [23:0]  a_full;
	logic [11:0]  col;
	logic [11:0]  raddr;
	logic [2:0]   dcnt;
	logic [2:0]   ocnt;
	logic         setf_done;
	logic         id_sel;
	logic [7:0]   out_sh;
	logic [7:0]   cur_byte;
	logic [3:0]   lane_out;
	logic [3:0]   lane_oe;
	logic [3:0]   pins;
	logic [2:0]   in_lanes;
	logic [7:0]   rd_data;
	logic         wr_en;
	logic         hold_ok;
	logic         opc_end;
	logic         addr_end;
	logic         byte_end;
	logic         fire;
	logic         qe_s1;
	logic         qe_s2;
	logic         qe_s3;
	logic         qe_l;
	// Event holding registers, read by the core after the request syncs
	logic         ev_req;
	snfe_act_t    ev_act;
	logic [23:0]  ev_addr;
	logic [7:0]   ev_data;
	// Core domain synchronisers
	logic         req_s1;
	logic         req_s2;
	logic         req_s3;
	logic         req_seen;
	logic         ev_new;
	logic         wp_s1;
	logic         wp_s2;
	logic         wp_s3;
	logic         wp_n_l;
	logic         wp_low;

	// Lanes in, newest bits at the bottom
	function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [2:0] la,
		input logic [3:0] p);
		case (la)
			L1:      return {v[22:0], p[0]};
			L2:      return {v[21:0], p[1:0]};
			default: return {v[19:0], p};
		endcase
	endfunction : shift_in

	// Last clock index of one byte at a lane count
	function automatic logic [2:0] byte_last(input logic [2:0] la);
		case (la)
			L1:      return 3'h7;
			L2:      return 3'h3;
			default: return 3'h1;
		endcase
	endfunction : byte_last

	assign pins     = {io_lane3_in, io_lane2_in, io_lane1_in, io_lane0_in};
	// Pause pin is lane 3 once quad mode is enabled, so pause is off then
	assign hold_ok  = qe_l | io_lane3_in;
	assign in_lanes = (state == L_OPC) ? L1 : (state == L_ADDR) ? cmd.addr_lanes : cmd.data_lanes;
	assign a_full   = shift_in(sh_in, in_lanes, pins);
	assign dec      = snfe_decode(a_full[7:0], qe_l);
	assign opc_end  = state == L_OPC && cnt == OPC_LAST;
	assign addr_end = state == L_ADDR && cnt == cmd.addr_clk - 5'h01;
	assign byte_end = state == L_DATA && dcnt == byte_last(cmd.data_lanes);
	// Writes past the last column are dropped
	assign wr_en    = hold_ok && byte_end && !cmd.dir_out && cmd.act == ACT_LOAD
		&& col <= COL_LAST;

	// Completed command events
	always_comb begin
		fire = 1'b0;
		if (hold_ok && opc_end)
			fire = dec.act == ACT_WRITE_LATCH_SET_CMD || dec.act == ACT_WRITE_LATCH_CLEAR_CMD || dec.act == ACT_RESET;
		else if (hold_ok && addr_end)
			fire = cmd.act == ACT_PREAD || cmd.act == ACT_PEXEC || cmd.act == ACT_ERASE;
		else if (hold_ok && byte_end)
			fire = cmd.act == ACT_SETF && !setf_done;
	end

	// Quad enable into the link domain; used only once two stages agree
	always_ff @(posedge sclk) begin
		qe_s1 <= quad_lane_enable;
		qe_s2 <= qe_s1;
		qe_s3 <= qe_s2;
		if (qe_s2 == qe_s3)
			qe_l <= qe_s3;
	end

	// Phase sequencer; select high ends the frame, also during a pause
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			state <= L_OPC;
			cnt   <= 5'h00;
		end else if (hold_ok) begin
			cnt <= cnt + 5'h01;
			unique case (state)
				L_OPC: if (opc_end) begin
					cnt   <= 5'h00;
					state <= (dec.act == ACT_NONE || dec.addr_clk == 5'h00) ? L_SKIP : L_ADDR;
				end
				L_ADDR: if (addr_end) begin
					cnt   <= 5'h00;
					state <= (cmd.dummy_clk != 4'h0) ? L_DUMMY : cmd.has_data ? L_DATA : L_SKIP;
				end
				L_DUMMY: if (cnt == {1'b0, cmd.dummy_clk} - 5'h01) begin
					cnt   <= 5'h00;
					state <= L_DATA;
				end
				L_DATA, L_SKIP: cnt <= 5'h00;
			endcase
		end
	end

	// Command latch at opcode end
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n)
			cmd <= CMD_NONE;
		else if (hold_ok && opc_end)
			cmd <= dec;
	end

	// Address and data input path
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			sh_in     <= 24'h000000;
			addr      <= 24'h000000;
			col       <= 12'h000;
			raddr     <= 12'h000;
			dcnt      <= 3'h0;
			setf_done <= 1'b0;
		end else if (hold_ok) begin
			sh_in <= a_full;
			if (addr_end) begin
				addr  <= a_full;
				col   <= a_full[11:0];
				raddr <= a_full[11:0];
			end
			if (state == L_DATA)
				dcnt <= byte_end ? 3'h0 : dcnt + 3'h1;
			if (wr_en)
				col <= col + 12'h001;
			if (fire && cmd.act == ACT_SETF)
				setf_done <= 1'b1;
			// Prefetch next byte; wrap at the page end
			if (state == L_DATA && cmd.dir_out && dcnt == 3'h0)
				raddr <= (raddr >= COL_LAST) ? 12'h000 : raddr + 12'h001;
		end
	end

	// Event request level, dropped on the first edge of each frame
	always_ff @(posedge sclk) begin
		if (!cs_n && hold_ok && state == L_OPC && cnt == 5'h00)
			ev_req <= 1'b0;
		else if (!cs_n && fire)
			ev_req <= 1'b1;
	end

	// Event payload, held until the next event
	always_ff @(posedge sclk) begin
		if (!cs_n && fire) begin
			ev_act  <= opc_end ? dec.act : cmd.act;
			ev_addr <= addr_end ? a_full : addr;
			ev_data <= a_full[7:0];
		end
	end

	snfe_cache_mem u_cache (
		.clk     (sclk),
		.wr_en   (wr_en),
		.wr_addr (col),
		.wr_data (a_full[7:0]),
		.rd_addr (raddr),
		.rd_data (rd_data)
	);

	// Byte to send: cache data, or the two identity codes alternating
	always_comb begin
		cur_byte = out_sh;
		if (ocnt == 3'h0)
			cur_byte = (cmd.act == ACT_ID) ? ((id_sel ^ addr[0]) ? PART_CODE : MFR_CODE) : rd_data;
	end

	// Output shifter on the falling edge
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			out_sh   <= 8'h00;
			ocnt     <= 3'h0;
			id_sel   <= 1'b0;
			lane_out <= 4'h0;
		end else if (hold_ok && state == L_DATA && cmd.dir_out) begin
			case (cmd.data_lanes)
				L1:      lane_out <= {2'b00, cur_byte[7], 1'b0};
				L2:      lane_out <= {2'b00, cur_byte[7:6]};
				default: lane_out <= cur_byte[7:4];
			endcase
			out_sh <= cur_byte << cmd.data_lanes;
			ocnt   <= (ocnt == byte_last(cmd.data_lanes)) ? 3'h0 : ocnt + 3'h1;
			if (ocnt == byte_last(cmd.data_lanes))
				id_sel <= ~id_sel;
		end
	end

	// Drive enables; held through a pause so the lanes return at once on exit
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n)
			lane_oe <= 4'h0;
		else if (hold_ok) begin
			if (state == L_DATA && cmd.dir_out) begin
				case (cmd.data_lanes)
					L1:      lane_oe <= OE_X1;
					L2:      lane_oe <= OE_X2;
					default: lane_oe <= OE_X4;
				endcase
			end else
				lane_oe <= 4'h0;
		end
	end

	assign io_lane0_out = lane_out[0];
	assign io_lane1_out = lane_out[1];
	assign io_lane2_out = lane_out[2];
	assign io_lane3_out = lane_out[3];
	// A pause floats the lanes at once, and its end restores them before the next rise
	assign io_lane0_oe  = lane_oe[0] & hold_ok;
	assign io_lane1_oe  = lane_oe[1] & hold_ok;
	assign io_lane2_oe  = lane_oe[2] & hold_ok;
	assign io_lane3_oe  = lane_oe[3] & hold_ok;

	// Request and protect pin into the core; act once two stages agree
	always_ff @(posedge mclk) begin
		req_s1 <= ev_req;
		req_s2 <= req_s1;
		req_s3 <= req_s2;
		wp_s1  <= io_lane2_in;
		wp_s2  <= wp_s1;
		wp_s3  <= wp_s2;
		if (!rstn)
			req_seen <= 1'b1;
		else if (req_s2 == req_s3)
			req_seen <= req_s3;
		if (!rstn)
			wp_n_l <= 1'b1;
		else if (wp_s2 == wp_s3)
			wp_n_l <= wp_s3;
	end

	assign ev_new = req_s2 == req_s3 && req_s3 && !req_seen;
	// Protect pin is lane 2 in quad mode, so it protects nothing then
	assign wp_low = !quad_lane_enable && !wp_n_l;

	// Core: write latch, busy, status and array requests
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			busy         <= 1'b0;
			write_latch  <= 1'b0;
			op_start     <= 1'b0;
			op_abort     <= 1'b0;
			op_kind      <= OP_READ;
			row_addr     <= 24'h000000;
			page_addr    <= 6'h00;
			block_addr   <= 11'h000;
			program_fail <= 1'b0;
			erase_fail   <= 1'b0;
			ecc_status   <= 2'h0;
		end else begin
			op_start <= 1'b0;
			op_abort <= 1'b0;
			// Completion runs on regardless of any link pause
			if (busy && op_done) begin
				busy <= 1'b0;
				unique case (op_kind)
					OP_READ:    ecc_status <= op_ecc;
					OP_PROGRAM: program_fail <= op_fail;
					OP_ERASE:   erase_fail <= op_fail;
				endcase
				if (op_kind != OP_READ)
					write_latch <= 1'b0;
			end
			if (ev_new) begin
				unique case (ev_act)
					ACT_WRITE_LATCH_SET_CMD: write_latch <= 1'b1;
					ACT_WRITE_LATCH_CLEAR_CMD: write_latch <= 1'b0;
					ACT_RESET: begin
						write_latch <= 1'b0;
						if (busy) begin
							busy     <= 1'b0;
							op_abort <= 1'b1;
						end else begin
							program_fail <= 1'b0;
							erase_fail   <= 1'b0;
							ecc_status   <= 2'h0;
						end
					end
					ACT_PREAD, ACT_PEXEC, ACT_ERASE: begin
						// Program and erase need the latch, page read does not; a request while busy is dropped
						if (!busy && (ev_act == ACT_PREAD || write_latch)) begin
							busy     <= 1'b1;
							op_start <= 1'b1;
							op_kind  <= (ev_act == ACT_PREAD) ? OP_READ :
								(ev_act == ACT_PEXEC) ? OP_PROGRAM : OP_ERASE;
							row_addr  <= ev_addr;
							page_addr <= ev_addr[PAGE_MSB:0];
							block_addr <= DENSITY_2G ? ev_addr[BLK_MSB_2G:BLK_LSB] :
								{1'b0, ev_addr[BLK_MSB_1G:BLK_LSB]};
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Feature bits written by set feature
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			protect_lock_enable <= 1'b0;
			prot_level_bit0     <= 1'b0;
			prot_level_bit1     <= 1'b0;
			prot_level_bit2     <= 1'b0;
			prot_invert         <= 1'b0;
			prot_complement     <= 1'b0;
			quad_lane_enable    <= 1'b0;
		end else if (ev_new && ev_act == ACT_SETF) begin
			if (ev_addr[7:0] == FEAT_PROT) begin
				protect_lock_enable <= ev_data[PB_LOCK];
				if (!(protect_lock_enable && wp_low)) begin
					prot_level_bit0 <= ev_data[PB_LVL0];
					prot_level_bit1 <= ev_data[PB_LVL1];
					prot_level_bit2 <= ev_data[PB_LVL2];
					prot_invert     <= ev_data[PB_INV];
					prot_complement <= ev_data[PB_CMP];
				end
			end
			if (ev_addr[7:0] == FEAT_CFG)
				quad_lane_enable <= ev_data[CB_QE];
		end
	end

endmodule : snfe_top

`default_nettype wire

//--- snfe_pkg.sv
// Shared constants, command table and decode for the serial NAND front end.
// Assumes both the link logic and the core logic import this package.
`default_nettype none

package snfe_pkg;

	// Page geometry: last valid column byte
	localparam logic [11:0] COL_LAST = 12'h87F;
	// Row address fields
	localparam int PAGE_MSB   = 5;
	localparam int BLK_LSB    = 6;
	localparam int BLK_MSB_1G = 15;
	localparam int BLK_MSB_2G = 16;

	// Opcodes
	localparam logic [7:0] OPC_WRITE_LATCH_SET_CMD  = 8'h06;
	localparam logic [7:0] OPC_WRITE_LATCH_CLEAR_CMD  = 8'h04;
	localparam logic [7:0] OPC_RESET = 8'hFF;
	localparam logic [7:0] OPC_SETF  = 8'h1F;
	localparam logic [7:0] OPC_PREAD = 8'h13;
	localparam logic [7:0] OPC_PEXEC = 8'h10;
	localparam logic [7:0] OPC_ERASE = 8'hD8;
	localparam logic [7:0] OPC_RD1   = 8'h03;
	localparam logic [7:0] OPC_RD1F  = 8'h0B;
	localparam logic [7:0] OPC_RD2   = 8'h3B;
	localparam logic [7:0] OPC_RD4   = 8'h6B;
	localparam logic [7:0] OPC_RDIO2 = 8'hBB;
	localparam logic [7:0] OPC_RDIO4 = 8'hEB;
	localparam logic [7:0] OPC_ID    = 8'h9F;
	localparam logic [7:0] OPC_LD1   = 8'h02;
	localparam logic [7:0] OPC_LDR1  = 8'h84;
	localparam logic [7:0] OPC_LD4   = 8'h32;
	localparam logic [7:0] OPC_LDR4  = 8'h34;
	localparam logic [7:0] OPC_LDR4B = 8'hC4;
	localparam logic [7:0] OPC_LDIO4 = 8'h72;

	// Feature addresses and bit positions
	localparam logic [7:0] FEAT_PROT = 8'hA0;
	localparam logic [7:0] FEAT_CFG  = 8'hB0;
	localparam int PB_LOCK = 7;
	localparam int PB_LVL2 = 5;
	localparam int PB_LVL1 = 4;
	localparam int PB_LVL0 = 3;
	localparam int PB_INV  = 2;
	localparam int PB_CMP  = 1;
	localparam int CB_QE   = 0;

	// Phase lengths in link clocks
	localparam logic [4:0] OPC_LAST = 5'h07;
	localparam logic [4:0] AC8      = 5'h08;
	localparam logic [4:0] AC16     = 5'h10;
	localparam logic [4:0] AC24     = 5'h18;
	localparam logic [4:0] AC16X2   = 5'h08;
	localparam logic [4:0] AC16X4   = 5'h04;
	localparam logic [3:0] DC8      = 4'h8;
	localparam logic [3:0] DC_IO2   = 4'h4;
	localparam logic [3:0] DC_IO4   = 4'h2;
	// Lane counts and drive masks
	localparam logic [2:0] L1     = 3'h1;
	localparam logic [2:0] L2     = 3'h2;
	localparam logic [2:0] L4     = 3'h4;
	localparam logic [3:0] OE_X1  = 4'h2;
	localparam logic [3:0] OE_X2  = 4'h3;
	localparam logic [3:0] OE_X4  = 4'hF;

	typedef enum logic [3:0] {
		ACT_NONE, ACT_WRITE_LATCH_SET_CMD, ACT_WRITE_LATCH_CLEAR_CMD, ACT_RESET, ACT_SETF,
		ACT_PREAD, ACT_PEXEC, ACT_ERASE, ACT_LOAD, ACT_CREAD, ACT_ID
	} snfe_act_t;

	typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_ERASE} snfe_op_t;

	typedef struct packed {
		snfe_act_t  act;
		logic [4:0] addr_clk;
		logic [2:0] addr_lanes;
		logic [3:0] dummy_clk;
		logic [2:0] data_lanes;
		logic       has_data;
		logic       dir_out;
	} snfe_cmd_t;

	localparam snfe_cmd_t CMD_NONE = '{ACT_NONE, 5'h00, L1, 4'h0, L1, 1'b0, 1'b0};

	// Opcode to phase layout; quad forms need the quad enable
	function automatic snfe_cmd_t snfe_decode(input logic [7:0] op, input logic qe);
		snfe_cmd_t c;
		c = CMD_NONE;
		case (op)
			OPC_WRITE_LATCH_SET_CMD:  c.act = ACT_WRITE_LATCH_SET_CMD;
			OPC_WRITE_LATCH_CLEAR_CMD:  c.act = ACT_WRITE_LATCH_CLEAR_CMD;
			OPC_RESET: c.act = ACT_RESET;
			OPC_SETF:  c = '{ACT_SETF, AC8, L1, 4'h0, L1, 1'b1, 1'b0};
			OPC_PREAD: c = '{ACT_PREAD, AC24, L1, 4'h0, L1, 1'b0, 1'b0};
			OPC_PEXEC: c = '{ACT_PEXEC, AC24, L1, 4'h0, L1, 1'b0, 1'b0};
			OPC_ERASE: c = '{ACT_ERASE, AC24, L1, 4'h0, L1, 1'b0, 1'b0};
			OPC_RD1, OPC_RD1F: c = '{ACT_CREAD, AC16, L1, DC8, L1, 1'b1, 1'b1};
			OPC_RD2:   c = '{ACT_CREAD, AC16, L1, DC8, L2, 1'b1, 1'b1};
			OPC_RDIO2: c = '{ACT_CREAD, AC16X2, L2, DC_IO2, L2, 1'b1, 1'b1};
			OPC_ID:    c = '{ACT_ID, AC8, L1, 4'h0, L1, 1'b1, 1'b1};
			OPC_LD1, OPC_LDR1: c = '{ACT_LOAD, AC16, L1, 4'h0, L1, 1'b1, 1'b0};
			OPC_RD4:   if (qe) c = '{ACT_CREAD, AC16, L1, DC8, L4, 1'b1, 1'b1};
			OPC_RDIO4: if (qe) c = '{ACT_CREAD, AC16X4, L4, DC_IO4, L4, 1'b1, 1'b1};
			OPC_LD4, OPC_LDR4, OPC_LDR4B: if (qe) c = '{ACT_LOAD, AC16, L1, 4'h0, L4, 1'b1, 1'b0};
			OPC_LDIO4: if (qe) c = '{ACT_LOAD, AC16X4, L4, 4'h0, L4, 1'b1, 1'b0};
			default:   c = CMD_NONE;
		endcase
		return c;
	endfunction : snfe_decode

endpackage : snfe_pkg

`default_nettype wire

//--- snfe_cache_mem.sv
// Page cache storage for one page plus spare, link clock domain.
// Assumes the caller keeps write addresses in range; read data is registered.
`default_nettype none

module snfe_cache_mem #(
	parameter int DEPTH = 2176
) (
	input  wire logic        clk,
	input  wire logic        wr_en,
	input  wire logic [11:0] wr_addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic [11:0] rd_addr,
	output logic      [7:0]  rd_data
);

	logic [7:0] mem [DEPTH];

	// Single write port
	always_ff @(posedge clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// Registered read, one clock of latency
	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end

endmodule : snfe_cache_mem

`default_nettype wire

//--- snfe_top_props.sv
// Checker for the front end: array start, finish, abort, row fields and lane 1 released while deselected.
// Assumes it is bound to snfe_top and sees only that module's ports.
`default_nettype none
module snfe_top_props
	import snfe_pkg::*;
#(
	parameter bit DENSITY_2G = 1'b0
) (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        cs_n,
	input wire logic        op_done,
	input wire logic        op_fail,
	input wire logic        op_start,
	input wire snfe_op_t    op_kind,
	input wire logic        op_abort,
	input wire logic [23:0] row_addr,
	input wire logic [5:0]  page_addr,
	input wire logic [10:0] block_addr,
	input wire logic        busy,
	input wire logic        write_latch,
	input wire logic        program_fail,
	input wire logic        io_lane1_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// Launch from idle, and the finish of a running operation
	sequence s_launch;
		!busy ##1 op_start;
	endsequence
	sequence s_finish;
		busy && op_done;
	endsequence
	chk_launch_idle: assert property (op_start |-> !$past(busy)) else $error("start while busy");
	chk_launch_busy: assert property (s_launch |=> busy) else $error("busy not set");
	chk_start_pulse: assert property (op_start |=> !op_start) else $error("start too long");
	chk_write_needs_latch: assert property (op_start && op_kind != OP_READ |-> $past(write_latch))
		else $error("write without latch");
	chk_finish_idle: assert property (s_finish |=> !busy) else $error("busy after finish");
	chk_finish_latch: assert property (s_finish ##0 op_kind != OP_READ |=> !write_latch)
		else $error("latch kept after finish");
	chk_fail_flag: assert property (s_finish ##0 op_kind == OP_PROGRAM |=> program_fail == $past(op_fail))
		else $error("fail flag wrong");
	chk_abort_busy: assert property (op_abort |-> $past(busy) ##1 (!op_abort && !busy))
		else $error("abort wrong");
	chk_page_field: assert property (op_start |-> page_addr == row_addr[5:0]) else $error("page field");
	chk_block_field: assert property (op_start |->
		block_addr == (DENSITY_2G ? row_addr[16:6] : {1'b0, row_addr[15:6]})) else $error("block field");
	chk_deselect_quiet: assert property (cs_n |-> !io_lane1_oe) else $error("lane driven when idle");
endmodule : snfe_top_props

bind snfe_top snfe_top_props #(.DENSITY_2G(DENSITY_2G)) snfe_top_props_inst (
	.mclk, .rstn, .cs_n, .op_done, .op_fail, .op_start, .op_kind, .op_abort, .row_addr,
	.page_addr, .block_addr, .busy, .write_latch, .program_fail, .io_lane1_oe);
`default_nettype wire

//--- snfe_host.sv
// Host controller model: link clock, select and lane levels for the front end.
// Assumes the bench calls its tasks one at a time; mode 0 unless mode3 is set.
`default_nettype none
module snfe_host (
	output logic            sclk,
	output logic            cs_n,
	output wire logic [3:0] lane,
	input  wire logic [3:0] dout,
	input  wire logic [3:0] doe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic h0      = 1'b0;
	logic flip    = 1'b0;
	logic wp_n    = 1'b1;
	logic hold_n  = 1'b1;
	logic mode3   = 1'b0;
	logic oe_seen = 1'b0;
	logic pz_oe   = 1'b0;
	// Released lane1 toggles so a stale bit never passes; lanes 2 and 3 carry wp_n and hold_n
	always #40 flip = ~flip;
	assign lane = {doe[3] ? dout[3] : hold_n, doe[2] ? dout[2] : wp_n, doe[1] ? dout[1] : flip, doe[0] ? dout[0] : h0};
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end
	// Select with the clock parked at the idle level of the mode
	task automatic open_frame();
		sclk = mode3;
		oe_seen = 1'b0;
		#80 cs_n = 1'b0;
	endtask : open_frame
	// Data changes with the clock low; the device samples on the rise
	task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			h0 = b[i];
			#80 sclk = 1'b1;
			r[i] = lane[1];
			oe_seen |= doe[1];
			#80;
		end
	endtask : xbyte
	// Pause over n clocks, entered and left with the clock low
	task automatic pause(input int n);
		sclk = 1'b0;
		#80 hold_n = 1'b0;
		pz_oe = 1'b0;
		repeat (n) begin
			#80 sclk = 1'b1;
			pz_oe |= doe[1];
			#80 sclk = 1'b0;
		end
		#80 hold_n = 1'b1;
		#80;
	endtask : pause
	// Park the clock, deselect, flip the released lane0, keep the gap
	task automatic close_frame();
		#80 sclk = mode3;
		#80 cs_n = 1'b1;
		h0 = ~h0;
		#300;
	endtask : close_frame
endmodule : snfe_host
`default_nettype wire

//--- tb_top.sv
// Bench for the serial NAND front end: host model frames, array engine finish driven here.
// Assumes the host model and the bound checker are compiled alongside.
`default_nettype none
module tb_top;
	import snfe_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MFR  = 8'h3C; // arbitrary value
	localparam logic [7:0] PART = 8'hC3; // arbitrary value
	logic       mclk    = 1'b0;
	logic       rstn    = 1'b0;
	logic       op_done = 1'b0;
	logic       op_fail = 1'b0;
	logic [1:0] op_ecc  = 2'h0;
	int         n_fail  = 0;
	int         checks_done = 0;
	int         n_start = 0;
	int         n_abort = 0;
	logic [7:0] rx [$];
	wire logic [3:0] lin, dout, doe;
	wire logic sclk, cs_n, op_start, op_abort, busy, write_latch, program_fail;
	wire logic protect_lock_enable, prot_level_bit0, prot_level_bit1, prot_level_bit2, prot_invert;
	wire logic [5:0]  page_addr;
	wire logic [10:0] block_addr;
	wire snfe_op_t    op_kind;
	wire logic [4:0]  prot = {protect_lock_enable, prot_level_bit2, prot_level_bit1, prot_level_bit0, prot_invert};
	snfe_top #(.MFR_CODE(MFR), .PART_CODE(PART), .DENSITY_2G(1'b0)) snfe_top_inst (
		.mclk, .rstn, .sclk, .cs_n, .io_lane0_in(lin[0]), .io_lane0_out(dout[0]), .io_lane0_oe(doe[0]),
		.io_lane1_in(lin[1]), .io_lane1_out(dout[1]), .io_lane1_oe(doe[1]), .io_lane2_in(lin[2]),
		.io_lane2_out(dout[2]), .io_lane2_oe(doe[2]), .io_lane3_in(lin[3]), .io_lane3_out(dout[3]),
		.io_lane3_oe(doe[3]), .op_done, .op_fail, .op_ecc, .op_start, .op_kind, .op_abort, .row_addr(),
		.page_addr, .block_addr, .busy, .write_latch, .program_fail, .erase_fail(), .ecc_status(),
		.protect_lock_enable, .prot_level_bit0, .prot_level_bit1, .prot_level_bit2, .prot_invert,
		.prot_complement(), .quad_lane_enable());
	snfe_host snfe_host_inst (.sclk, .cs_n, .lane(lin), .dout, .doe);
	initial forever #25 mclk = ~mclk;
	// Count the one-cycle pulses of the core
	always @(posedge mclk) begin
		if (op_start === 1'b1) n_start++;
		if (op_abort === 1'b1) n_abort++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		checks_done++;
		if (got !== want) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic wrap_up();
		if (n_fail == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	// One frame; the wait after it covers the crossing of the event into the core
	task automatic frame(input logic [7:0] tx [$], input int nrd = 0, input int pz = -1);
		logic [7:0] r;
		rx.delete();
		snfe_host_inst.open_frame();
		foreach (tx[i]) snfe_host_inst.xbyte(tx[i], r);
		for (int i = 0; i < nrd; i++) begin
			snfe_host_inst.xbyte(8'h00, r);
			rx.push_back(r);
			if (i == pz) snfe_host_inst.pause(3);
		end
		snfe_host_inst.close_frame();
		repeat (6) @(posedge mclk);
		#2;
	endtask : frame
	// Array engine finishing the running operation
	task automatic done_op(input logic f);
		@(posedge mclk);
		#2 op_done = 1'b1;
		op_fail = f;
		repeat (3) @(posedge mclk);
		#2 op_done = 1'b0;
	endtask : done_op
	initial begin
		int s;
		repeat (5) @(posedge mclk);
		#2 rstn = 1'b1;
		repeat (5) @(posedge mclk);
		snfe_host_inst.mode3 = 1'b1;
		frame({8'h06});
		chk(16'(write_latch), 16'h0001);
		snfe_host_inst.mode3 = 1'b0;
		frame({8'h04});
		chk(16'(write_latch), 16'h0000);
		// Erase refused without the latch, then a program that fails
		s = n_start;
		frame({8'hD8, 8'h00, 8'h00, 8'h40});
		chk(16'(n_start - s), 16'h0000);
		frame({8'h06});
		frame({8'h10, 8'h00, 8'h41, 8'hC5});
		chk({15'(n_start - s), busy}, 16'h0003);
		chk({op_kind, page_addr, block_addr[7:0]}, {OP_PROGRAM, 6'h05, 8'h07});
		chk(16'(block_addr), 16'h0107);
		done_op(1'b1);
		chk({14'h0, write_latch, program_fail}, 16'h0001);
		frame({8'hFF});
		chk(16'(program_fail), 16'h0000);
		frame({8'h06});
		frame({8'hFF});
		chk(16'(write_latch), 16'h0000);
		// Reset while a page read runs aborts it
		s = n_abort;
		frame({8'h13, 8'h00, 8'h00, 8'h02});
		chk({13'h0, op_kind, busy}, {13'h0, OP_READ, 1'b1});
		frame({8'hFF});
		chk({15'(n_abort - s), busy}, 16'h0002);
		// Last valid column and column zero read back across the wrap
		frame({8'h02, 8'h08, 8'h7F, 8'h96});
		frame({8'h02, 8'h00, 8'h00, 8'h69});
		frame({8'h03, 8'h08, 8'h7F, 8'h00}, 2);
		chk({rx[0], rx[1]}, 16'h9669);
		// Pause between two read bytes: lane released, no bit lost
		frame({8'h84, 8'h00, 8'h10, 8'h3C, 8'hC3});
		frame({8'h0B, 8'h00, 8'h10, 8'h00}, 2, 0);
		chk({rx[0], rx[1]}, 16'h3CC3);
		chk(16'(snfe_host_inst.pz_oe), 16'h0000);
		frame({8'h9F, 8'h00}, 2);
		chk({rx[0], rx[1]}, {MFR, PART});
		// Protection bits written, frozen by lock and low protect pin, then cleared
		frame({8'h1F, 8'hA0, 8'hBC});
		chk(16'(prot), 16'h001F);
		snfe_host_inst.wp_n = 1'b0;
		frame({8'h1F, 8'hA0, 8'h80, 8'h00});
		chk(16'(prot), 16'h001F);
		snfe_host_inst.wp_n = 1'b1;
		frame({8'h1F, 8'hA0, 8'h00, 8'h00});
		chk(16'(prot), 16'h0000);
		// Unknown and quad-only opcodes leave the output lane undriven
		frame({8'h0F, 8'hA0}, 1);
		chk(16'(snfe_host_inst.oe_seen), 16'h0000);
		frame({8'h6B, 8'h00, 8'h00, 8'h00}, 1);
		chk(16'(snfe_host_inst.oe_seen), 16'h0000);
		wrap_up();
	end
	// About 105 us of traffic expected; cut a hang well after that
	initial begin
		#2000000;
		n_fail++;
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
